// *** rtl/cbir_board.sv ***
// module: board end, master and cascaded slave controllers with backplane routing
`timescale 1ns/1ps

// How it works
// - two controllers, eight prioritised inputs each
// - backplane lines monitored by default, optionally driven
// - default jumper cascades slave on master input seven
// - direct mode: slave, serial supply own vectors
// - nondirect mode: no on-board vector, cpu polls slave
// - one mode shared by all three devices
// - bus-vectored level: backplane device gives vector
// - master inputs routable except six; slave only zero-two
// - master input six never takes backplane
// - serial request enters level six with vector
// - returned vectors always above thirty-one
module cbir_board (
  input  wire logic               clock_in,
  input  wire logic               resetn_in,
  cbir_if.board                   cpu_if,
  input  wire cbir_pkg::cbir_mode_t mode_in,            // shared vectoring mode
  input  wire logic [7:0]         onboard_req_in,       // on-board sources per master input
  input  wire logic [7:0]         master_from_bus_in,   // jumper: master input takes backplane
  input  wire logic [7:0]         bus_vectored_in,      // master levels that are bus-vectored
  input  wire logic [7:0]         master_mask_in,       // one masks a master level
  input  wire logic [7:0]         master_base_in,       // master vector base
  input  wire logic [2:0]         slave_routed_req_in,  // jumpered slave sources
  input  wire logic [2:0]         slave_from_bus_in,    // jumper: slave input takes backplane
  input  wire logic [7:3]         slave_fixed_req_in,   // hard-wired slave sources
  input  wire logic [7:0]         slave_mask_in,        // one masks a slave level
  input  wire logic [7:0]         slave_base_in,        // slave vector base
  input  wire logic               serial_service_request_in, // either channel needs service
  input  wire logic [7:0]         serial_vector_in,     // vector from serial_controller
  input  wire logic [7:0]         bus_vector_in,        // vector placed by backplane device
  input  wire logic [7:0]         bp_line_in,           // backplane lines, active low
  input  wire logic [7:0]         bp_drive_en_in,       // jumper: board drives this line
  input  wire logic [7:0]         bp_assert_in,         // request to assert a driven line
  output logic      [7:0]         bp_line_out,          // open-drain data, always low
  output logic      [7:0]         bp_line_oe_out        // high while pulling a line low
);

  // ************************************************************
  // ****** helpers
  // ************************************************************
  // lowest index wins: level zero is the highest priority
  function automatic logic [2:0] cbir_first(input logic [7:0] vec);
    logic [2:0] idx;
    idx = cbir_pkg::LEVEL_RESET;
    for (int i = cbir_pkg::NUM_LEVELS - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // keeps every returned vector byte out of the internal exception range; the no-vector byte stays zero
  function automatic logic [7:0] cbir_lift(input logic [7:0] vec);
    return (vec <= cbir_pkg::RESERVED_VEC_MAX) ? (vec | cbir_pkg::VEC_FLOOR_BIT) : vec;
  endfunction

  // ************************************************************
  // ****** backplane lines
  // ************************************************************
  // a line is either driven or watched, never both; default is watched
  wire  [7:0] bp_seen = ~bp_line_in & ~bp_drive_en_in;
  assign bp_line_out    = 8'h00;                                 // only ever pulls low
  assign bp_line_oe_out = bp_drive_en_in & bp_assert_in;

  // ************************************************************
  // ****** slave controller inputs
  // ************************************************************
  logic [7:0] slave_src;                                         // routed slave requests
  always_comb begin
    slave_src[7:3] = slave_fixed_req_in;                         // fixed sources
    for (int i = 0; i < cbir_pkg::SLAVE_ROUTED; i++) begin
      slave_src[i] = slave_from_bus_in[i] ? bp_seen[i] : slave_routed_req_in[i];
    end
  end

  wire  [7:0] slave_pend    = slave_src & ~slave_mask_in;
  wire        slave_any     = |slave_pend;                       // cascade output
  wire  [2:0] slave_hi      = cbir_first(slave_pend);

  // ************************************************************
  // ****** master controller inputs
  // ************************************************************
  logic [7:0] master_src;                                        // routed master requests
  always_comb begin
    for (int i = 0; i < cbir_pkg::NUM_LEVELS; i++) begin
      // default jumpers: six is serial, seven is the cascaded slave
      if (3'(i) == cbir_pkg::SERIAL_LEVEL) begin
        master_src[i] = serial_service_request_in | onboard_req_in[i];
      end else if (master_from_bus_in[i]) begin
        master_src[i] = bp_seen[i];
      end else if (3'(i) == cbir_pkg::CASCADE_LEVEL) begin
        master_src[i] = slave_any | onboard_req_in[i];
      end else begin
        master_src[i] = onboard_req_in[i];
      end
    end
  end

  // level six cannot be bus-vectored even if its option bit is set
  wire  [7:0] six_bit       = 8'h01 << cbir_pkg::SERIAL_LEVEL;
  wire  [7:0] bus_vec_lvls  = bus_vectored_in & ~six_bit;

  // ************************************************************
  // ****** priority resolution against in-service levels
  // ************************************************************
  logic [7:0] in_service_ff;                                     // acked, awaiting eoi
  logic [7:0] nxt_in_service;
  logic [7:0] isr_block;                                         // same and lower levels

  wire  [2:0] isr_hi        = cbir_first(in_service_ff);
  // a level is blocked by itself and any higher level in service
  always_comb begin
    isr_block = 8'h00;
    for (int i = 0; i < cbir_pkg::NUM_LEVELS; i++) begin
      isr_block[i] = (|in_service_ff) && (3'(i) >= isr_hi);
    end
  end

  wire  [7:0] master_pend   = master_src & ~master_mask_in & ~isr_block;
  wire        master_any    = |master_pend;
  wire  [2:0] master_hi     = cbir_first(master_pend);
  wire  [2:0] ack_level     = master_any ? master_hi : cbir_pkg::SPURIOUS_LEVEL;

  // ************************************************************
  // ****** vector selection at acknowledge
  // ************************************************************
  wire        is_nondirect  = (mode_in == cbir_pkg::CBIR_NONDIRECT);
  wire        lvl_bus       = bus_vec_lvls[ack_level];
  wire        lvl_cascade   = (ack_level == cbir_pkg::CASCADE_LEVEL) && !master_from_bus_in[7];
  wire        lvl_serial    = (ack_level == cbir_pkg::SERIAL_LEVEL);
  wire  [7:0] master_vec    = {master_base_in[7:3], ack_level};
  wire  [7:0] slave_vec     = {slave_base_in[7:3], slave_hi};
  logic [7:0] raw_vec;                                           // vector before lifting

  // bus-vectored levels take the byte the backplane device drives
  always_comb begin
    if (lvl_bus) begin
      raw_vec = bus_vector_in;
    end else if (lvl_cascade) begin
      raw_vec = slave_vec;
    end else if (lvl_serial) begin
      raw_vec = serial_vector_in;
    end else begin
      raw_vec = master_vec;
    end
  end

  // nondirect applies to on-board direct devices; bus levels keep their vector
  wire        give_none     = is_nondirect && !lvl_bus;

  // ************************************************************
  // ****** request and answer registers
  // ************************************************************
  logic       req_ff;                                            // cpu_maskable_request
  logic       nxt_req;
  logic       vec_valid_ff;                                      // vector strobe
  logic       vec_none_ff;                                       // no-vector marker
  logic [7:0] vec_data_ff;                                       // vector byte
  logic       poll_valid_ff;                                     // poll strobe
  logic [3:0] poll_data_ff;                                      // {pending, level}

  // request rises on any pending level and falls only at acknowledge
  assign nxt_req = cpu_if.ack ? cbir_pkg::REQ_RESET : (req_ff | master_any);

  // set wins over eoi clear so a new acknowledge is never lost
  wire  [7:0] ack_bit       = 8'h01 << ack_level;
  wire  [7:0] eoi_bit       = (|in_service_ff) ? (8'h01 << isr_hi) : 8'h00;
  assign nxt_in_service = (in_service_ff & ~(cpu_if.eoi ? eoi_bit : 8'h00))
                        | (cpu_if.ack ? ack_bit : 8'h00);

  // request hold and in-service tracking
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      req_ff        <= cbir_pkg::REQ_RESET;
      in_service_ff <= cbir_pkg::BYTE_RESET;
    end else begin
      req_ff        <= nxt_req;
      in_service_ff <= nxt_in_service;
    end
  end

  // vector answer, one cycle after acknowledge
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      vec_valid_ff <= cbir_pkg::REQ_RESET;
      vec_none_ff  <= cbir_pkg::REQ_RESET;
      vec_data_ff  <= cbir_pkg::BYTE_RESET;
    end else begin
      vec_valid_ff <= cpu_if.ack;
      if (cpu_if.ack) begin
        vec_none_ff <= give_none;
        vec_data_ff <= give_none ? cbir_pkg::BYTE_RESET : cbir_lift(raw_vec);
      end
    end
  end

  // poll answer: slave reports its highest pending level
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      poll_valid_ff <= cbir_pkg::REQ_RESET;
      poll_data_ff  <= cbir_pkg::POLL_RESET;
    end else begin
      poll_valid_ff <= cpu_if.poll;
      if (cpu_if.poll) begin
        poll_data_ff <= {slave_any, slave_hi};
      end
    end
  end

  // ************************************************************
  // ****** outputs
  // ************************************************************
  assign cpu_if.cpu_maskable_request = req_ff;
  assign cpu_if.vec_valid            = vec_valid_ff;
  assign cpu_if.vec_none             = vec_none_ff;
  assign cpu_if.vec_data             = vec_data_ff;
  assign cpu_if.poll_valid           = poll_valid_ff;
  assign cpu_if.poll_data            = poll_data_ff;

endmodule

// *** rtl/cbir_pkg.sv ***
// package: shared constants, modes and states of the board interrupt routing
package cbir_pkg;

  // ************************************************************
  // ****** structure
  // ************************************************************
  localparam int unsigned NUM_LEVELS   = 8;                 // inputs per controller
  localparam logic [2:0]  SERIAL_LEVEL = 3'h6;              // serial_controller input
  localparam logic [2:0]  CASCADE_LEVEL = 3'h7;             // slave enters here
  localparam logic [2:0]  SPURIOUS_LEVEL = 3'h7;            // answer when nothing pends
  localparam int unsigned SLAVE_ROUTED = 3;                 // slave inputs zero to two
  localparam logic [7:0]  RESERVED_VEC_MAX = 8'h1F;         // vectors 0..31 internal
  localparam logic [7:0]  VEC_FLOOR_BIT = 8'h20;            // forced into user vectors

  // ************************************************************
  // ****** reset values
  // ************************************************************
  localparam logic        REQ_RESET   = 1'b0;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;
  localparam logic [2:0]  LEVEL_RESET = 3'h0;
  localparam logic [3:0]  POLL_RESET  = 4'h0;

  // ************************************************************
  // ****** vectoring mode, one for both controllers and serial
  // ************************************************************
  typedef enum logic [1:0] {
    CBIR_DIRECT,      // sources supply vectors
    CBIR_NONDIRECT    // on-board sources give no vector, cpu polls
  } cbir_mode_t;

  // ************************************************************
  // ****** cpu end sequencer states
  // ************************************************************
  typedef enum logic [2:0] {
    CBIR_IDLE,
    CBIR_ACK,
    CBIR_WAIT_VEC,
    CBIR_POLL,
    CBIR_WAIT_POLL,
    CBIR_DONE
  } cbir_cpu_state_t;

endpackage

// *** rtl/cbir_if.sv ***
// interface: interrupt request, acknowledge, vector and poll path to the cpu
`timescale 1ns/1ps
interface cbir_if;
  logic       cpu_maskable_request;  // board to cpu, level, held until ack
  logic       ack;                   // cpu to board, one-cycle acknowledge
  logic       vec_valid;             // board to cpu, one-cycle vector strobe
  logic       vec_none;              // with vec_valid: no vector, poll instead
  logic [7:0] vec_data;              // vector byte, valid with vec_valid
  logic       poll;                  // cpu to board, one-cycle poll request
  logic       poll_valid;            // board to cpu, one-cycle poll answer
  logic [3:0] poll_data;             // {pending, slave level}
  logic       eoi;                   // cpu to board, one-cycle end of service

  modport board (
    output cpu_maskable_request, vec_valid, vec_none, vec_data, poll_valid, poll_data,
    input  ack, poll, eoi
  );
  modport cpu (
    input  cpu_maskable_request, vec_valid, vec_none, vec_data, poll_valid, poll_data,
    output ack, poll, eoi
  );
endinterface

// *** rtl/cbir_cpu.sv ***
// module: cpu end, acknowledge sequencer that fetches a vector or polls the slave
`timescale 1ns/1ps
module cbir_cpu (
  input  wire logic       clock_in,
  input  wire logic       resetn_in,
  cbir_if.cpu             board_if,
  input  wire logic       enable_in,         // interrupts accepted while high
  output logic            service_valid_out, // one-cycle: service decided
  output logic            service_polled_out,// service came from a poll
  output logic [7:0]      service_vector_out,// vector taken at acknowledge
  output logic [3:0]      service_poll_out,  // {pending, slave level} from poll
  output logic            reserved_hit_out   // vector fell in reserved range
);

  // ************************************************************
  // ****** sequencer
  // ************************************************************
  cbir_pkg::cbir_cpu_state_t state_ff;        // current step
  cbir_pkg::cbir_cpu_state_t nxt_state;
  logic [7:0]                vec_ff;           // captured vector
  logic [3:0]                poll_ff;          // captured poll answer
  logic                      polled_ff;        // answer came by poll
  logic                      reserved_ff;      // sticky reserved-vector flag

  // one acknowledge per request, then vector or poll, then eoi
  always_comb begin
    case (state_ff)
      cbir_pkg::CBIR_IDLE: begin
        nxt_state = (enable_in && board_if.cpu_maskable_request)
                    ? cbir_pkg::CBIR_ACK : cbir_pkg::CBIR_IDLE;
      end
      cbir_pkg::CBIR_ACK: begin
        nxt_state = cbir_pkg::CBIR_WAIT_VEC;
      end
      cbir_pkg::CBIR_WAIT_VEC: begin
        if (!board_if.vec_valid) begin
          nxt_state = cbir_pkg::CBIR_WAIT_VEC;
        end else if (board_if.vec_none) begin
          nxt_state = cbir_pkg::CBIR_POLL;
        end else begin
          nxt_state = cbir_pkg::CBIR_DONE;
        end
      end
      cbir_pkg::CBIR_POLL: begin
        nxt_state = cbir_pkg::CBIR_WAIT_POLL;
      end
      cbir_pkg::CBIR_WAIT_POLL: begin
        nxt_state = board_if.poll_valid ? cbir_pkg::CBIR_DONE : cbir_pkg::CBIR_WAIT_POLL;
      end
      cbir_pkg::CBIR_DONE: begin
        nxt_state = cbir_pkg::CBIR_IDLE;
      end
      default: begin
        nxt_state = cbir_pkg::CBIR_IDLE;
      end
    endcase
  end

  // state and captured answers
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff    <= cbir_pkg::CBIR_IDLE;
      vec_ff      <= cbir_pkg::BYTE_RESET;
      poll_ff     <= cbir_pkg::POLL_RESET;
      polled_ff   <= cbir_pkg::REQ_RESET;
      reserved_ff <= cbir_pkg::REQ_RESET;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == cbir_pkg::CBIR_WAIT_VEC && board_if.vec_valid) begin
        vec_ff    <= board_if.vec_data;
        polled_ff <= board_if.vec_none;
        // a hardware vector must never land on an exception slot
        if (!board_if.vec_none && board_if.vec_data <= cbir_pkg::RESERVED_VEC_MAX) begin
          reserved_ff <= 1'b1;
        end
      end
      if (state_ff == cbir_pkg::CBIR_WAIT_POLL && board_if.poll_valid) begin
        poll_ff <= board_if.poll_data;
      end
    end
  end

  // ************************************************************
  // ****** outputs
  // ************************************************************
  assign board_if.ack        = (state_ff == cbir_pkg::CBIR_ACK);
  assign board_if.poll       = (state_ff == cbir_pkg::CBIR_POLL);
  assign board_if.eoi        = (state_ff == cbir_pkg::CBIR_DONE);
  assign service_valid_out   = (state_ff == cbir_pkg::CBIR_DONE);
  assign service_polled_out  = polled_ff;
  assign service_vector_out  = vec_ff;
  assign service_poll_out    = poll_ff;
  assign reserved_hit_out    = reserved_ff;

endmodule

// *** bench/cbir_properties.sv ***
// checker: timing relations on the request, acknowledge, vector and poll path
`timescale 1ns/1ps
module cbir_properties (
  input wire logic       clock_in,
  input wire logic       resetn_in,
  input wire logic       cpu_maskable_request,
  input wire logic       ack,
  input wire logic       vec_valid,
  input wire logic       vec_none,
  input wire logic [7:0] vec_data,
  input wire logic       poll,
  input wire logic       poll_valid,
  input wire logic [3:0] poll_data,
  input wire logic       eoi
);
  // one clock domain, so clocking and reset are given once
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  a_vec_after_ack: assert property (ack |=> vec_valid && !cpu_maskable_request)
    else $error("no vector strobe or request still high after acknowledge");
  a_strobe_has_cause: assert property (vec_valid |-> $past(ack))
    else $error("vector strobe without acknowledge");
  a_ack_needs_request: assert property (ack |-> $past(cpu_maskable_request) && !$past(ack))
    else $error("acknowledge without a held request");
  a_vector_not_reserved: assert property (vec_valid && !vec_none |-> vec_data > 8'h1F)
    else $error("vector inside the reserved range");
  a_nondirect_polls: assert property (vec_valid && vec_none |-> vec_data == 8'h00 ##1 poll)
    else $error("missing vector not followed by a poll");
  a_direct_then_eoi: assert property (vec_valid && !vec_none |=> eoi && !poll)
    else $error("direct vector not closed by end of service");
  a_poll_answer: assert property (poll |=> poll_valid ##1 eoi)
    else $error("poll not answered and closed");
  a_vector_holds: assert property (!vec_valid |-> $stable(vec_data))
    else $error("vector byte moved without a strobe");
  a_poll_holds: assert property (!poll_valid |-> $stable(poll_data))
    else $error("poll byte moved without a strobe");
endmodule

// *** bench/tb_cascaded_board_interrupt_routing.sv ***
// testbench: random and corner traffic through board and cpu ends joined by the interface
`timescale 1ns/1ps
module tb_cascaded_board_interrupt_routing;
  logic                 clock_in, resetn_in, en, serial_req, svalid, spolled, rhit;
  cbir_pkg::cbir_mode_t mode;
  logic [7:0]           onb, mfb, bvec, mmask, mbase, smask, sbase, svec, busv;
  logic [7:0]           bpl, bpen, bpas, bp_out, bp_oe, svector;
  logic [2:0]           sreq;   // jumpered slave sources
  logic [2:0]           sfb;    // slave inputs zero to two taken from the backplane
  logic [7:3]           sfix;   // hard-wired slave sources
  logic [3:0]           spoll;
  int                   n_errors, compares, seed;

  cbir_if u_cbir_if ();
  cbir_board u_cbir_board (.clock_in(clock_in), .resetn_in(resetn_in), .cpu_if(u_cbir_if.board),
    .mode_in(mode), .onboard_req_in(onb), .master_from_bus_in(mfb), .bus_vectored_in(bvec),
    .master_mask_in(mmask), .master_base_in(mbase), .slave_routed_req_in(sreq),
    .slave_from_bus_in(sfb), .slave_fixed_req_in(sfix), .slave_mask_in(smask),
    .slave_base_in(sbase), .serial_service_request_in(serial_req), .serial_vector_in(svec),
    .bus_vector_in(busv), .bp_line_in(bpl), .bp_drive_en_in(bpen), .bp_assert_in(bpas),
    .bp_line_out(bp_out), .bp_line_oe_out(bp_oe));
  cbir_cpu u_cbir_cpu (.clock_in(clock_in), .resetn_in(resetn_in), .board_if(u_cbir_if.cpu),
    .enable_in(en), .service_valid_out(svalid), .service_polled_out(spolled),
    .service_vector_out(svector), .service_poll_out(spoll), .reserved_hit_out(rhit));
  cbir_properties u_props (.clock_in(clock_in), .resetn_in(resetn_in),
    .cpu_maskable_request(u_cbir_if.cpu_maskable_request), .ack(u_cbir_if.ack),
    .vec_valid(u_cbir_if.vec_valid), .vec_none(u_cbir_if.vec_none),
    .vec_data(u_cbir_if.vec_data), .poll(u_cbir_if.poll), .poll_valid(u_cbir_if.poll_valid),
    .poll_data(u_cbir_if.poll_data), .eoi(u_cbir_if.eoi));

  // ************************************************************
  // ****** expectation and comparison
  // ************************************************************
  // winning level, vector and poll byte worked out from the board inputs
  function automatic void predict(output logic any, output logic pol, output logic [7:0] v,
                                  output logic [3:0] pd);
    logic [7:0] sp, mp;
    int         lv, sl;
    sp = {sfix, sreq};
    // only the three jumpered slave inputs may watch a backplane line
    for (int i = 0; i < 3; i++) if (sfb[i]) sp[i] = !bpl[i] && !bpen[i];
    sp = sp & ~smask;
    sl = 7;
    for (int i = 7; i >= 0; i--) if (sp[i]) sl = i;
    for (int i = 0; i < 8; i++) mp[i] = mfb[i] ? (!bpl[i] && !bpen[i]) : onb[i];
    mp[6] = onb[6] | serial_req;
    mp[7] = |sp;
    mp = mp & ~mmask;
    lv = 7;
    for (int i = 7; i >= 0; i--) if (mp[i]) lv = i;
    any = |mp;
    pol = mode == cbir_pkg::CBIR_NONDIRECT && !(bvec[lv] && lv != 6);
    if (bvec[lv] && lv != 6) v = busv;
    else if (lv == 7) v = {sbase[7:3], 3'(sl)};
    else if (lv == 6) v = svec;
    else v = {mbase[7:3], 3'(lv)};
    if (v <= cbir_pkg::RESERVED_VEC_MAX) v = v | cbir_pkg::VEC_FLOOR_BIT;
    pd = {|sp, 3'(sl)};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      n_errors++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  // one service: wait a bounded time, then compare what the cpu end took
  task automatic trial(input string name, input logic on);
    logic       any, pol;
    logic [7:0] v;
    logic [3:0] pd, keep;
    int         k;
    predict(any, pol, v, pd);
    keep = {1'b1, {3{pd[3]}}};  // slave level means nothing when the slave is quiet
    k = 0;
    while (svalid !== 1'b1 && k < 24) begin
      @(posedge clock_in);
      #1;
      k++;
    end
    check({7'h0, svalid}, {7'h0, any & on});
    if (!on) check({7'h0, u_cbir_if.cpu_maskable_request}, {7'h0, any});
    else if (any) begin
      check({7'h0, spolled}, {7'h0, pol});
      if (pol) check({4'h0, spoll & keep}, {4'h0, pd & keep});
      else check(svector, v);
    end
    check(bp_oe, bpen & bpas);
    check(bp_out, 8'h00);
    $display("test %s done", name);
  endtask

  // ************************************************************
  // ****** stimulus
  // ************************************************************
  task automatic randomize_inputs();
    logic [31:0] r1, r2, r3, r4;
    r1 = $random(seed);
    r2 = $random(seed);
    r3 = $random(seed);
    r4 = $random(seed);
    @(posedge clock_in);
    onb <= r1[7:0] & 8'h7F;    // level seven stays with the slave
    mfb <= r1[15:8] & 8'h7F;   // slave kept cascaded on level seven
    bvec <= r1[23:16];
    mmask <= r1[31:24] & r2[7:0];
    {mbase, sbase, svec, busv} <= r2;
    {bpl, bpen, bpas, smask} <= r3;
    sreq <= r4[2:0];
    sfb <= r4[12:10];
    sfix <= r4[7:3];
    serial_req <= r4[8];
    mode <= cbir_pkg::cbir_mode_t'({1'b0, r4[9]});
  endtask

  // requests withdrawn; leftover services run out before the next trial
  task automatic settle();
    @(posedge clock_in);
    en <= 1'b1;
    onb <= 8'h00;
    serial_req <= 1'b0;
    sreq <= 3'h0;
    sfix <= 5'h00;
    bpl <= 8'hFF;
    repeat (12) @(posedge clock_in);
  endtask

  task automatic final_report();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  // watchdog: far beyond some two hundred trials of about twenty cycles
  initial begin
    #2_000_000;
    n_errors++;
    final_report();
  end

  initial begin
    seed = 86;
    resetn_in = 1'b0;
    en = 1'b1;
    serial_req = 1'b0;
    mode = cbir_pkg::CBIR_DIRECT;
    {onb, mfb, bvec, mmask, mbase, smask, sbase, svec, busv, bpen, bpas} = '0;
    bpl = 8'hFF;
    sreq = 3'h0;
    sfb = 3'h0;
    sfix = 5'h00;
    repeat (2) @(posedge clock_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    // zero base on level zero must be lifted out of the reserved range
    randomize_inputs();
    {mmask, mbase, bvec, mfb, onb} <= 40'hFE_00_00_00_01;
    mode <= cbir_pkg::CBIR_DIRECT;
    #1;
    trial("low base", 1'b1);
    settle();
    // backplane jumpered and bus-vectored on level six still yields the serial vector
    randomize_inputs();
    {mmask, mfb, bvec, bpl, bpen} <= 40'hBF_40_40_00_00;
    {serial_req, svec} <= 9'h191;
    mode <= cbir_pkg::CBIR_DIRECT;
    #1;
    trial("level six", 1'b1);
    settle();
    // cpu disabled: request must stand unanswered
    randomize_inputs();
    en <= 1'b0;
    #1;
    trial("disabled", 1'b0);
    settle();
    repeat (200) begin
      randomize_inputs();
      #1;
      trial("random", 1'b1);
      settle();
    end
    check({7'h0, rhit}, 8'h00);
    final_report();
  end
endmodule
